// >>> rtl/fsp_cfg.svh
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
// =====================================
// Array geometry
`define FSP_NSEC 16
`define FSP_SECW 4
`define FSP_SEC_LSB 16
// =====================================
// Frame lengths in link clocks
`define FSP_CNT_MAX 7'h7F
`define FSP_LEN_OP 7'h08
`define FSP_LEN_OVR 7'h10
`define FSP_LEN_LOCK 7'h18
`define FSP_LEN_ADR 7'h28
`define FSP_LEN_VWR 7'h30
`define FSP_LEN_PW 7'h48
`define FSP_DUMMY 7'h08
// =====================================
// Instruction codes
`define FSP_OP_WEN 8'h06
`define FSP_OP_RESET 8'h99
`define FSP_OP_SCHEME 8'h68
`define FSP_OP_SECRD 8'h2B
`define FSP_OP_LKWR 8'h2C
`define FSP_OP_LKRD 8'h2D
`define FSP_OP_PWWR 8'h28
`define FSP_OP_PWUL 8'h29
`define FSP_OP_PLSET 8'hA6
`define FSP_OP_PLRD 8'hA7
`define FSP_OP_PPGM 8'hE3
`define FSP_OP_PERS 8'hE4
`define FSP_OP_PRD 8'hE2
`define FSP_OP_VWR 8'hE1
`define FSP_OP_VRD 8'hE0
`define FSP_OP_GLK 8'h7E
`define FSP_OP_GULK 8'h98
`define FSP_OP_OVR 8'hE5
`define FSP_OP_PROG 8'h12
`define FSP_OP_ERASE 8'hDC
// =====================================
// Register layout and reset values
`define FSP_LOCK_RST 16'hFFFF
`define FSP_PW_RST 64'hFFFF_FFFF_FFFF_FFFF
`define FSP_PERS_BIT 1
`define FSP_PASS_BIT 2
`define FSP_BYTE_PROT 8'hFF
`define FSP_BYTE_OPEN 8'h00
`endif

// >>> rtl/fsp_pkg.sv
`include "fsp_cfg.svh"
package fsp_pkg;
  typedef enum logic [4:0] {
    FSP_C_NONE = 5'h00, FSP_C_WEN = 5'h01, FSP_C_RESET = 5'h02, FSP_C_SCHEME = 5'h03,
    FSP_C_SECRD = 5'h04, FSP_C_LKWR = 5'h05, FSP_C_LKRD = 5'h06, FSP_C_PWWR = 5'h07,
    FSP_C_PWUL = 5'h08, FSP_C_PLSET = 5'h09, FSP_C_PLRD = 5'h0A, FSP_C_PPGM = 5'h0B,
    FSP_C_PERS = 5'h0C, FSP_C_PRD = 5'h0D, FSP_C_VWR = 5'h0E, FSP_C_VRD = 5'h0F,
    FSP_C_GLK = 5'h10, FSP_C_GULK = 5'h11, FSP_C_OVR = 5'h12, FSP_C_PROG = 5'h13,
    FSP_C_ERASE = 5'h14
  } fsp_cmd_t;

  function automatic fsp_cmd_t fsp_decode(input logic [7:0] op);
    case (op)
      `FSP_OP_WEN: return FSP_C_WEN;
      `FSP_OP_RESET: return FSP_C_RESET;
      `FSP_OP_SCHEME: return FSP_C_SCHEME;
      `FSP_OP_SECRD: return FSP_C_SECRD;
      `FSP_OP_LKWR: return FSP_C_LKWR;
      `FSP_OP_LKRD: return FSP_C_LKRD;
      `FSP_OP_PWWR: return FSP_C_PWWR;
      `FSP_OP_PWUL: return FSP_C_PWUL;
      `FSP_OP_PLSET: return FSP_C_PLSET;
      `FSP_OP_PLRD: return FSP_C_PLRD;
      `FSP_OP_PPGM: return FSP_C_PPGM;
      `FSP_OP_PERS: return FSP_C_PERS;
      `FSP_OP_PRD: return FSP_C_PRD;
      `FSP_OP_VWR: return FSP_C_VWR;
      `FSP_OP_VRD: return FSP_C_VRD;
      `FSP_OP_GLK: return FSP_C_GLK;
      `FSP_OP_GULK: return FSP_C_GULK;
      `FSP_OP_OVR: return FSP_C_OVR;
      `FSP_OP_PROG: return FSP_C_PROG;
      `FSP_OP_ERASE: return FSP_C_ERASE;
      default: return FSP_C_NONE;
    endcase
  endfunction : fsp_decode

  function automatic logic fsp_is_read(input fsp_cmd_t c);
    return c inside {FSP_C_SECRD, FSP_C_LKRD, FSP_C_PLRD, FSP_C_PRD, FSP_C_VRD};
  endfunction : fsp_is_read
endpackage : fsp_pkg

// >>> rtl/fsp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
// How it works
// - Scheme select sets security bit seven
// - Write-protect pin low protects every sector
// - Persistent and volatile bit per sector
// - Shipped part acts as persistent method
// - Method lock bits are one-time programmable
// - Clearing both method bits aborts write
// - Bit2 zero password, bit1 zero persistent
// - Method fixed: later writes fail, flag set
// - Persistent lock resets per selected method
// - Persistent lock read: bit0 one means open
// - Persistent method: only reset releases lock
// - Password unlock releases persistent lock
// - Program one persistent bit, erase all
// - Locked persistent commands leave bits unchanged
// - Persistent read gives 00h or FFh
// - Reset sets all volatile bits protected
// - Volatile write sets, read gives 00h/FFh
// - Modify only when volatile bit clear and persistent bit clear or overridden
// - Override bit masks persistent protection
// - Open: volatile zero, persistent or override zero
// - Gang lock and unlock need write enable
// - Protected program or erase is ignored
module fsp_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  input wire logic wp_n_i,
  output logic [`FSP_NSEC-1:0] sector_protect_o,
  output logic array_go_o,
  output logic array_erase_o,
  output logic [`FSP_SECW-1:0] array_sector_o
);
  function automatic logic [`FSP_SECW-1:0] sec_of(input logic [31:0] a);
    return a[`FSP_SEC_LSB+`FSP_SECW-1:`FSP_SEC_LSB];
  endfunction : sec_of

  function automatic logic [7:0] bsel(input logic b);
    return b ? `FSP_BYTE_PROT : `FSP_BYTE_OPEN;
  endfunction : bsel

  // =====================================
  // Link side, on the host's clock
  logic fresh_r, rq_tgl_r, ack_meta_r, ack_sync_r, ack_tgl_r, req_fire, load_now, req_new;
  logic [6:0] cnt_r, cnt_nxt, load_at_r, req_len;
  logic [7:0] op_r, op_nxt, rq_op_r;
  logic [63:0] shift_r, shift_nxt;
  logic [31:0] adr_r;
  logic [`FSP_SECW-1:0] rq_sec_r;
  logic [15:0] out_r, out_nxt, resp_r, resp_sel;
  fsp_pkg::fsp_cmd_t lk_cmd;

  assign cnt_nxt = fresh_r ? 7'h01 :
                   (cnt_r == `FSP_CNT_MAX) ? cnt_r : cnt_r + 7'h01;
  assign op_nxt = (cnt_nxt <= `FSP_LEN_OP) ? {op_r[6:0], spi_mosi_i} : op_r;
  assign shift_nxt = {shift_r[62:0], spi_mosi_i};
  assign lk_cmd = fsp_pkg::fsp_decode(op_nxt);
  assign req_len = (lk_cmd == fsp_pkg::FSP_C_PRD || lk_cmd == fsp_pkg::FSP_C_VRD) ?
                   `FSP_LEN_ADR : `FSP_LEN_OP;
  assign req_fire = fsp_pkg::fsp_is_read(lk_cmd) && (cnt_nxt == req_len);
  // Data only leaves once the core has answered this very request
  assign load_now = (load_at_r != 7'h00) && (cnt_nxt == load_at_r) &&
                    (ack_sync_r == rq_tgl_r);
  assign out_nxt = load_now ? resp_r : {out_r[14:0], 1'b0};

  // Chip select high restarts the frame without needing a clock edge
  always_ff @(posedge spi_clk_i or posedge spi_cs_n_i or posedge rst_i)
  begin
    if (rst_i || spi_cs_n_i)
      fresh_r <= 1'b1;
    else
      fresh_r <= 1'b0;
  end

  always_ff @(posedge spi_clk_i or posedge spi_cs_n_i or posedge rst_i)
  begin
    if (rst_i || spi_cs_n_i)
      spi_miso_oe_o <= 1'b0;
    else if (load_now)
      spi_miso_oe_o <= 1'b1;
  end

  // Frame fields stay put after the frame, the core reads them then
  always_ff @(posedge spi_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 7'h00;
      op_r <= 8'h00;
      shift_r <= 64'h0000_0000_0000_0000;
      adr_r <= 32'h0000_0000;
      out_r <= 16'h0000;
      ack_meta_r <= 1'b0;
      ack_sync_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      shift_r <= shift_nxt;
      out_r <= out_nxt;
      ack_meta_r <= ack_tgl_r;
      ack_sync_r <= ack_meta_r;
      if (cnt_nxt == `FSP_LEN_ADR)
        adr_r <= shift_nxt[31:0];
    end
  end

  always_ff @(posedge spi_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rq_op_r <= 8'h00;
      rq_sec_r <= '0;
      rq_tgl_r <= 1'b0;
      load_at_r <= 7'h00;
    end
    else if (req_fire)
    begin
      rq_op_r <= op_nxt;
      rq_sec_r <= sec_of(shift_nxt[31:0]);
      rq_tgl_r <= ~rq_tgl_r;
      load_at_r <= cnt_nxt + `FSP_DUMMY;
    end
    else if (fresh_r)
      load_at_r <= 7'h00;
  end

  assign spi_miso_o = out_r[15];

  // =====================================
  // Crossings into the core clock
  logic cs_meta_r, cs_sync_r, cs_prev_r, rq_meta_r, rq_sync_r, rq_prev_r, wp_meta_r, wp_sync_r;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {cs_meta_r, cs_sync_r, cs_prev_r} <= 3'h7;
      {rq_meta_r, rq_sync_r, rq_prev_r} <= 3'h0;
      {wp_meta_r, wp_sync_r} <= 2'h0;
    end
    else
    begin
      {cs_meta_r, cs_sync_r, cs_prev_r} <= {spi_cs_n_i, cs_meta_r, cs_sync_r};
      {rq_meta_r, rq_sync_r, rq_prev_r} <= {rq_tgl_r, rq_meta_r, rq_sync_r};
      {wp_meta_r, wp_sync_r} <= {wp_n_i, wp_meta_r};
    end
  end

  // =====================================
  // Command decode at frame end
  logic scheme_r, plock_r, plock_nxt, ovr_r, wel_r, pfail_r, efail_r, fe, wr_go, sect, vbit;
  logic [15:0] lock_r, lock_nxt, d;
  logic [63:0] pw_r;
  logic [`FSP_NSEC-1:0] pers_r, pers_nxt, vol_r, vol_nxt, a_oh, prot_now;
  logic [`FSP_SECW-1:0] a_sec;
  fsp_pkg::fsp_cmd_t cmd, rq_cmd;

  function automatic logic hit(input fsp_pkg::fsp_cmd_t c, input logic [6:0] len);
    return (cmd == c) && (cnt_r == len);
  endfunction : hit

  assign cmd = fsp_pkg::fsp_decode(op_r);
  assign fe = cs_sync_r & ~cs_prev_r;
  assign wr_go = fe & wel_r;
  assign sect = wr_go & scheme_r;
  assign a_sec = sec_of(adr_r);
  assign a_oh = `FSP_NSEC'(1) << a_sec;
  assign d = shift_r[15:0];

  logic ev_wen, ev_rst, ev_sch, ev_lk, ev_pww, ev_pwu, ev_pls, ev_ppg;
  logic ev_per, ev_vwr, ev_glk, ev_gul, ev_ovr, ev_arr, is_erase;
  assign ev_wen = fe & hit(fsp_pkg::FSP_C_WEN, `FSP_LEN_OP);
  assign ev_rst = fe & hit(fsp_pkg::FSP_C_RESET, `FSP_LEN_OP);
  assign ev_sch = wr_go & hit(fsp_pkg::FSP_C_SCHEME, `FSP_LEN_OP);
  assign ev_lk = sect & hit(fsp_pkg::FSP_C_LKWR, `FSP_LEN_LOCK);
  assign ev_pww = sect & lock_r[`FSP_PASS_BIT] & hit(fsp_pkg::FSP_C_PWWR, `FSP_LEN_PW);
  assign ev_pwu = sect & ~lock_r[`FSP_PASS_BIT] & hit(fsp_pkg::FSP_C_PWUL, `FSP_LEN_PW);
  assign ev_pls = sect & hit(fsp_pkg::FSP_C_PLSET, `FSP_LEN_OP);
  assign ev_ppg = sect & hit(fsp_pkg::FSP_C_PPGM, `FSP_LEN_ADR);
  assign ev_per = sect & hit(fsp_pkg::FSP_C_PERS, `FSP_LEN_OP);
  assign ev_vwr = sect & hit(fsp_pkg::FSP_C_VWR, `FSP_LEN_VWR);
  assign ev_glk = sect & hit(fsp_pkg::FSP_C_GLK, `FSP_LEN_OP);
  assign ev_gul = sect & hit(fsp_pkg::FSP_C_GULK, `FSP_LEN_OP);
  assign ev_ovr = sect & hit(fsp_pkg::FSP_C_OVR, `FSP_LEN_OVR);
  assign is_erase = cmd == fsp_pkg::FSP_C_ERASE;
  assign ev_arr = wr_go & (hit(fsp_pkg::FSP_C_ERASE, `FSP_LEN_ADR) |
                  ((cmd == fsp_pkg::FSP_C_PROG) & (cnt_r >= `FSP_LEN_VWR)));

  assign prot_now = {`FSP_NSEC{scheme_r}} &
                    ({`FSP_NSEC{~wp_sync_r}} | vol_r | (pers_r & {`FSP_NSEC{ovr_r}}));

  // =====================================
  // Method lock and persistent lock
  logic m_locked, lk_both, lk_none, lk_ok, lk_bad, pw_ok, arr_prot, arr_go;
  assign m_locked = ~lock_r[`FSP_PERS_BIT] | ~lock_r[`FSP_PASS_BIT];
  assign lk_both = ~d[`FSP_PERS_BIT] & ~d[`FSP_PASS_BIT];
  assign lk_none = d[`FSP_PERS_BIT] & d[`FSP_PASS_BIT];
  assign lk_ok = ev_lk & ~m_locked & ~lk_both & ~lk_none;
  assign lk_bad = ev_lk & (m_locked | lk_both);
  assign lock_nxt = lk_ok ? {lock_r[15:3], lock_r[2:1] & d[2:1], lock_r[0]} : lock_r;
  assign pw_ok = shift_r == pw_r;
  assign plock_nxt = ev_rst ? lock_r[`FSP_PASS_BIT] :
                     ev_pls ? 1'b0 :
                     (ev_pwu & pw_ok) ? 1'b1 : plock_r;
  assign arr_prot = prot_now[a_sec];
  assign arr_go = ev_arr & ~arr_prot;

  // =====================================
  // Sector bits
  // set one, erase all
  assign pers_nxt = (ev_per & plock_r) ? '0 :
                    (ev_ppg & plock_r) ? (pers_r | a_oh) : pers_r;
  assign vbit = shift_r[7:0] != `FSP_BYTE_OPEN;
  assign vol_nxt = (ev_rst | ev_glk) ? '1 :
                   ev_gul ? '0 :
                   ev_vwr ? ((vol_r & ~a_oh) | (vbit ? a_oh : '0)) : vol_r;

  // =====================================
  // Fail flags, set wins over clear
  logic pf_set, pf_clr, ef_set, ef_clr;
  assign pf_set = lk_bad | (ev_pwu & ~pw_ok) | (ev_ppg & ~plock_r) |
                  (ev_arr & arr_prot & ~is_erase);
  assign pf_clr = lk_ok | (ev_ppg & plock_r) | (arr_go & ~is_erase);
  assign ef_set = (ev_per & ~plock_r) | (ev_arr & arr_prot & is_erase);
  assign ef_clr = (ev_per & plock_r) | (arr_go & is_erase);

  // =====================================
  // Read answers
  assign rq_cmd = fsp_pkg::fsp_decode(rq_op_r);
  assign req_new = rq_sync_r ^ rq_prev_r;
  assign resp_sel =
    (rq_cmd == fsp_pkg::FSP_C_SECRD) ? {scheme_r, efail_r, pfail_r, 13'h0000} :
    (rq_cmd == fsp_pkg::FSP_C_LKRD) ? lock_r :
    (rq_cmd == fsp_pkg::FSP_C_PLRD) ? {7'h00, plock_r, 8'h00} :
    (rq_cmd == fsp_pkg::FSP_C_PRD) ? {bsel(pers_r[rq_sec_r]), 8'h00} :
    (rq_cmd == fsp_pkg::FSP_C_VRD) ? {bsel(vol_r[rq_sec_r]), 8'h00} : 16'h0000;

  // =====================================
  // Core registers
  // shipped method default
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scheme_r <= 1'b0;
      lock_r <= `FSP_LOCK_RST;
      pw_r <= `FSP_PW_RST;
      plock_r <= 1'b1;
      pers_r <= '0;
      vol_r <= '1;
      ovr_r <= 1'b1;
      wel_r <= 1'b0;
      pfail_r <= 1'b0;
      efail_r <= 1'b0;
    end
    else
    begin
      scheme_r <= scheme_r | ev_sch;
      lock_r <= lock_nxt;
      pw_r <= ev_pww ? (pw_r & shift_r) : pw_r;
      plock_r <= plock_nxt;
      pers_r <= pers_nxt;
      vol_r <= vol_nxt;
      ovr_r <= ev_rst ? 1'b1 : ev_ovr ? shift_r[0] : ovr_r;
      wel_r <= ev_wen ? 1'b1 : (fe & ~fsp_pkg::fsp_is_read(cmd)) ? 1'b0 : wel_r;
      pfail_r <= pf_set | (pfail_r & ~pf_clr);
      efail_r <= ef_set | (efail_r & ~ef_clr);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      resp_r <= 16'h0000;
      ack_tgl_r <= 1'b0;
      sector_protect_o <= '1;
      array_go_o <= 1'b0;
      array_erase_o <= 1'b0;
      array_sector_o <= '0;
    end
    else
    begin
      resp_r <= req_new ? resp_sel : resp_r;
      ack_tgl_r <= rq_sync_r;
      sector_protect_o <= prot_now;
      array_go_o <= arr_go;
      array_erase_o <= arr_go ? is_erase : array_erase_o;
      array_sector_o <= arr_go ? a_sec : array_sector_o;
    end
  end

  // =====================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  scheme_sticky_a: assert property (ev_sch |=> scheme_r ##1 scheme_r)
    else $error("scheme bit not set");
  wp_protect_a: assert property (scheme_r && !wp_sync_r |=> &sector_protect_o)
    else $error("pin low left a sector open");
  refuse_prot_a: assert property (ev_arr && arr_prot
    |=> !array_go_o && (pfail_r || efail_r))
    else $error("protected sector accepted");
  lock_otp_a: assert property (!lock_r[`FSP_PERS_BIT] |=> !lock_r[`FSP_PERS_BIT])
    else $error("method bit returned to one");
  lock_abort_a: assert property (ev_lk && lk_both |=> $stable(lock_r) && pfail_r)
    else $error("double clear changed lock");
  lock_fail_a: assert property (ev_lk && m_locked |=> pfail_r && $stable(lock_r))
    else $error("fixed method accepted write");
  plock_hold_a: assert property (lock_r[`FSP_PASS_BIT] && !plock_r && !ev_rst
    |=> !plock_r)
    else $error("persistent lock released");
  pers_locked_a: assert property ((ev_ppg || ev_per) && !plock_r |=> $stable(pers_r))
    else $error("locked persistent bits moved");
  reset_cmd_a: assert property (ev_rst |=> &vol_r && ovr_r)
    else $error("reset left volatile bits open");
  open_sector_a: assert property ((scheme_r && wp_sync_r && !vol_r[0] && !pers_r[0]) [*2]
    |-> !sector_protect_o[0])
    else $error("open sector shown protected");
  read_ack_a: assert property (req_new |=> ack_tgl_r == rq_tgl_r ##1 !req_new)
    else $error("read request not answered");

  pw_unlock_c: cover property (ev_pwu && pw_ok);
  lock_apply_c: cover property (lk_ok);
  array_go_c: cover property (arr_go);
  gang_open_c: cover property (ev_gul ##[1:50] arr_go);
endmodule : fsp_top
`default_nettype wire

// >>> tb/fsp_host.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// Host link model, clock stands still between frames
module fsp_host (
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i,
  input wire logic spi_miso_oe_i
);
  localparam realtime HALF = 7.5;
  logic oe_seen;

  initial
  begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
    oe_seen = 1'b0;
  end

  task automatic tick();
    #(HALF);
    spi_clk_o = 1'b1;
    #(HALF);
    spi_clk_o = 1'b0;
  endtask : tick

  task automatic xfer(input logic [71:0] v, input int n, input int r, output logic [15:0] din);
    int i;
    din = 16'h0000;
    oe_seen = 1'b1;
    spi_cs_n_o = 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      spi_mosi_o = v[i];
      tick();
    end
    if (r > 0)
    begin
      // Dummy and read phase: line toggles, never looks like real data
      for (i = 1; i < 8 + r; i++)
      begin
        spi_mosi_o = ~spi_mosi_o;
        tick();
        if (i >= 8)
        begin
          din = {din[14:0], spi_miso_i};
          oe_seen = oe_seen & spi_miso_oe_i;
        end
      end
    end
    #(HALF);
    spi_cs_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
    // Covers cs high minimum and core execution delay
    #80;
  endtask : xfer
endmodule : fsp_host
`default_nettype wire

// >>> tb/test_flash_sector_protection.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsp_cfg.svh"
module test_flash_sector_protection;
  localparam int LIMIT = 80000;
  localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  wire logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [`FSP_NSEC-1:0] prot;
  logic go, go_er_w, go_er;
  logic [`FSP_SECW-1:0] go_sec_w, go_sec;
  int go_cnt = 0;
  int g0;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] d;

  always #2 clock_i = ~clock_i;

  fsp_top fsp_top_inst (.clock_i(clock_i), .rst_i(rst_i), .spi_clk_i(spi_clk),
    .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
    .spi_miso_oe_o(spi_miso_oe), .wp_n_i(wp_n_i), .sector_protect_o(prot),
    .array_go_o(go), .array_erase_o(go_er_w), .array_sector_o(go_sec_w));
  fsp_host fsp_host_inst (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
    .spi_miso_i(spi_miso), .spi_miso_oe_i(spi_miso_oe));

  // =====================================
  // Array strobe capture and hang guard
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (go === 1'b1)
    begin
      go_cnt <= go_cnt + 1;
      go_sec <= go_sec_w;
      go_er <= go_er_w;
    end
    if (cyc == LIMIT)
    begin
      miscompares = miscompares + 1;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // =====================================
  // Frame helpers
  task automatic fr(input logic [71:0] v, input int n, input int r);
    fsp_host_inst.xfer(v, n, r, d);
  endtask : fr

  task automatic cmd(input logic [7:0] op);
    fr({64'h0, op}, 8, 0);
  endtask : cmd

  task automatic wcmd(input logic [7:0] op, input logic [63:0] arg, input int n);
    cmd(8'h06);
    fr(({64'h0, op} << n) | {8'h00, arg}, n + 8, 0);
  endtask : wcmd

  function automatic logic [63:0] adr(input logic [3:0] s, input int sh);
    return {28'h0, s, 16'h0000} << sh;
  endfunction : adr

  task automatic rd(input logic [7:0] op, input int na, input logic [3:0] s, input int r);
    fr(na ? (({64'h0, op} << 32) | {8'h00, adr(s, 0)}) : {64'h0, op}, na ? 40 : 8, r);
  endtask : rd

  task automatic cp(input logic [15:0] e);
    check("sector_protect_o", prot, e);
  endtask : cp

  task automatic byte_rd(input logic [7:0] op, input logic [3:0] s, input logic [7:0] e);
    rd(op, 1, s, 8);
    check("sector byte", d, {8'h00, e});
    check("miso enable", 16'(fsp_host_inst.oe_seen), 16'h0001);
  endtask : byte_rd

  task automatic sec_bit(input int b, input logic e);
    rd(8'h2B, 0, 4'h0, 8);
    check("security bit", 16'(d[b]), 16'(e));
  endtask : sec_bit

  task automatic plock(input logic [7:0] e);
    rd(8'hA7, 0, 4'h0, 8);
    check("persistent lock", d, {8'h00, e});
  endtask : plock

  task automatic mlock(input logic [15:0] e);
    rd(8'h2D, 0, 4'h0, 16);
    check("method lock", d, e);
  endtask : mlock

  task automatic go_chk(input int n, input logic [3:0] s, input logic er);
    check("array go count", 16'(go_cnt - g0), 16'(n));
    if (n > 0)
      check("array target", {11'h0, go_er, go_sec}, {11'h0, er, s});
  endtask : go_chk

  task automatic reset_pulse();
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask : reset_pulse

  // =====================================
  // Test sequence
  initial
  begin
    reset_pulse();
    cmd(8'h68);
    sec_bit(7, 1'b0);
    wcmd(8'h68, 64'h0, 0);
    sec_bit(7, 1'b1);
    cp(16'hFFFF);
    byte_rd(8'hE0, 4'h2, 8'hFF);
    mlock(16'hFFFF);
    plock(8'h01);
    $display("test scheme done");
    cmd(8'h98);
    cp(16'hFFFF);
    wcmd(8'h98, 64'h0, 0);
    cp(16'h0000);
    wcmd(8'h7E, 64'h0, 0);
    cp(16'hFFFF);
    wcmd(8'h98, 64'h0, 0);
    wcmd(8'hE1, adr(4'h3, 8) | 64'h5A, 40);
    cp(16'h0008);
    byte_rd(8'hE0, 4'h3, 8'hFF);
    byte_rd(8'hE0, 4'h4, 8'h00);
    @(posedge clock_i);
    wp_n_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    cp(16'hFFFF);
    wp_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    cp(16'h0008);
    $display("test volatile done");
    g0 = go_cnt;
    wcmd(8'h12, adr(4'h5, 8) | 64'hA5, 40);
    go_chk(1, 4'h5, 1'b0);
    g0 = go_cnt;
    wcmd(8'h12, adr(4'h3, 8) | 64'hA5, 40);
    go_chk(0, 4'h3, 1'b0);
    sec_bit(5, 1'b1);
    wcmd(8'hDC, adr(4'h3, 0), 32);
    go_chk(0, 4'h3, 1'b1);
    sec_bit(6, 1'b1);
    wcmd(8'hDC, adr(4'h6, 0), 32);
    go_chk(1, 4'h6, 1'b1);
    $display("test array done");
    wcmd(8'hE3, adr(4'h7, 0), 32);
    byte_rd(8'hE2, 4'h7, 8'hFF);
    byte_rd(8'hE2, 4'h6, 8'h00);
    cp(16'h0088);
    wcmd(8'hE5, 64'h00, 8);
    cp(16'h0008);
    byte_rd(8'hE2, 4'h7, 8'hFF);
    wcmd(8'hE5, 64'h01, 8);
    cp(16'h0088);
    wcmd(8'hE4, 64'h0, 0);
    byte_rd(8'hE2, 4'h7, 8'h00);
    wcmd(8'hE3, adr(4'h9, 0), 32);
    wcmd(8'hA6, 64'h0, 0);
    plock(8'h00);
    wcmd(8'hE3, adr(4'h8, 0), 32);
    byte_rd(8'hE2, 4'h8, 8'h00);
    sec_bit(5, 1'b1);
    wcmd(8'hE4, 64'h0, 0);
    byte_rd(8'hE2, 4'h9, 8'hFF);
    sec_bit(6, 1'b1);
    cmd(8'h99);
    plock(8'h01);
    cp(16'hFFFF);
    wcmd(8'h98, 64'h0, 0);
    cp(16'h0200);
    wcmd(8'hE4, 64'h0, 0);
    $display("test persistent done");
    wcmd(8'hE3, adr(4'hA, 0), 32);
    sec_bit(5, 1'b0);
    wcmd(8'h2C, 64'hFFFE, 16);
    mlock(16'hFFFF);
    sec_bit(5, 1'b0);
    wcmd(8'h2C, 64'hFFF9, 16);
    mlock(16'hFFFF);
    sec_bit(5, 1'b1);
    wcmd(8'h2C, 64'hFFFD, 16);
    mlock(16'hFFFD);
    sec_bit(5, 1'b0);
    wcmd(8'h2C, 64'hFFFB, 16);
    mlock(16'hFFFD);
    sec_bit(5, 1'b1);
    cmd(8'h99);
    plock(8'h01);
    $display("test method lock done");
    reset_pulse();
    wcmd(8'h68, 64'h0, 0);
    wcmd(8'h28, PW, 64);
    wcmd(8'h2C, 64'hFFFB, 16);
    mlock(16'hFFFB);
    cmd(8'h99);
    plock(8'h00);
    wcmd(8'hE3, adr(4'h1, 0), 32);
    byte_rd(8'hE2, 4'h1, 8'h00);
    wcmd(8'h98, 64'h0, 0);
    wcmd(8'h12, adr(4'h2, 8) | 64'hA5, 40);
    sec_bit(5, 1'b0);
    wcmd(8'h29, PW ^ 64'h1, 64);
    plock(8'h00);
    sec_bit(5, 1'b1);
    wcmd(8'h29, PW, 64);
    plock(8'h01);
    wcmd(8'hE3, adr(4'h1, 0), 32);
    byte_rd(8'hE2, 4'h1, 8'hFF);
    wcmd(8'hA6, 64'h0, 0);
    plock(8'h00);
    $display("test password done");
    results();
  end
endmodule : test_flash_sector_protection
`default_nettype wire
